//--- logic/smlc_pkg.sv
//------------------------------------------------------------------
// Overview of operation
// R1: RTS guards the local receive buffer and CTS gates sending; always active.
// R2: Six modem lines; ring and carrier detect each selectable as input or output.
// R3: Ring, carrier, ready and DTR under program control; RTS/CTS fixed to UART.
// R4: Dial, pairable or bond command with ready deasserted is refused with error.
// R5: Ready drop in a call enters command state; beyond delay the link drops.
// R6: Ring output rests low, asserts on incoming call until answered or rejected.
// R7: Carrier detect is low with no connection, high while connected.
// R8: Pin three is general or DTR; pure host mode forces DTR, high when linked.
// R9: General pins three to nine are bidirectional general inputs and outputs.
// R10: Four remote modem bits exchanged, each mappable to any local modem line; the code maps only to DTR, DSR, ring and carrier detect.
// R11: Receive line held in break beyond 100 ms causes a hardware reset.
// R12: A host break is never forwarded to the remote peer.
// R13: Cable replacement mode links up after power-up and retries endlessly.
// R14: Master waits a retry delay after failure; 2 s default, 100 to 15000 ms.
// R15: In ready drop mode a deasserted ready line gives command mode, not data.
// R16: The host keeps ready asserted (low at TTL) for auto connection.
// R17: Slave with stored peer accepts only that peer, otherwise any device.
// R18: Divided oscillator optionally driven on a chosen general pin, 8 or 16 MHz; the 16 MHz setting is capped at mclk/2, 10 MHz.
// R19: The host honours RTS/CTS handshake and stops when RTS is deasserted.
// R20: Every modem status input passes a two-stage synchroniser before use.
//------------------------------------------------------------------
package smlc_pkg;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * (CLK_HZ / 1_000_000);
  localparam int BREAK_MS = 100;
  localparam int RETRY_DEF_MS = 2000;
  localparam int RETRY_MIN_MS = 100;
  localparam int RETRY_MAX_MS = 15000;
  localparam int CLKOUT_LO_HZ = 8_000_000;
  localparam int CLKOUT_HI_HZ = 16_000_000;
  // General pins
  localparam int GP_FIRST = 3;
  localparam int GP_COUNT = 7;
  // Local line codes for the remote bit map
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_DTR = 3'h1;
  localparam logic [2:0] SEL_DSR = 3'h2;
  localparam logic [2:0] SEL_RI = 3'h3;
  localparam logic [2:0] SEL_DCD = 3'h4;
  // Remote bit positions
  localparam int RB_RTR = 0;
  localparam int RB_RTC = 1;
  localparam int RB_DV = 2;
  localparam int RB_IC = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DIAL = 3'h1,
    ST_RETRY = 3'h2,
    ST_RING = 3'h3,
    ST_LINK = 3'h4,
    ST_CMD = 3'h5
  } smlc_state_t;

  typedef struct packed {
    logic ringIsOut;
    logic dcdIsOut;
    logic pin3IsDtr;
    logic pureHost;
    logic cableMode;
    logic isMaster;
    logic readyDrop;
    logic peerValid;
    logic clkOutEn;
    logic clkOutHi;
    logic [2:0] clkOutPin;
    logic [3:0][2:0] rmtMap;
    logic [15:0] disconnectMs;
    logic [15:0] retryMs;
    logic [47:0] peerAddr;
  } smlc_cfg_t;

  typedef struct packed {
    logic dial;
    logic pairable;
    logic bond;
    logic answer;
    logic hangup;
  } smlc_cmd_t;

  typedef struct packed {
    logic linkUp;
    logic linkFail;
    logic linkLost;
    logic incoming;
    logic [47:0] incomingAddr;
  } smlc_link_t;
endpackage : smlc_pkg

//--- logic/smlc_line_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module smlc_line_ctrl
  import smlc_pkg::*;
#(
  parameter int MS_CYCLES = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Configuration, commands and radio events
  input wire smlc_cfg_t cfg,
  input wire smlc_cmd_t cmd,
  input wire smlc_link_t link,
  input wire logic [3:0] rmtIn,
  // UART side
  input wire logic rxPin,
  input wire logic rxNearFull,
  input wire logic ctsPin,
  output logic rtsPin,
  output logic txEnable,
  // Modem lines
  input wire logic dsrPin_b,
  input wire logic ringPinIn,
  output logic ringPinOut,
  output logic ringPinOe,
  input wire logic dcdPinIn,
  output logic dcdPinOut,
  output logic dcdPinOe,
  // General pins three to nine
  input wire logic [GP_COUNT-1:0] gpIn,
  input wire logic [GP_COUNT-1:0] swGpOut,
  input wire logic [GP_COUNT-1:0] swGpOe,
  output logic [GP_COUNT-1:0] gpOut,
  output logic [GP_COUNT-1:0] gpOe,
  output logic [GP_COUNT-1:0] gpSeen,
  // Status and requests to the radio
  output logic [3:0] rmtOut,
  output logic dialReq,
  output logic answerReq,
  output logic rejectReq,
  output logic dropReq,
  output logic cmdError,
  output logic cmdMode,
  output logic dataPass,
  output logic breakReset,
  output logic [2:0] connState
);

  //------------------------------------------------------------------
  // Functions
  //------------------------------------------------------------------
  // Keeps the retry delay inside its legal range
  function automatic logic [15:0] clampRetry(input logic [15:0] ms);
    if (ms < 16'(RETRY_MIN_MS)) begin
      return 16'(RETRY_MIN_MS);
    end else if (ms > 16'(RETRY_MAX_MS)) begin
      return 16'(RETRY_MAX_MS);
    end
    return ms;
  endfunction : clampRetry

  // Level of a remote bit routed onto one local line, plus a hit flag
  function automatic logic [1:0] mapHit(input logic [3:0][2:0] map,
                                        input logic [3:0] bits,
                                        input logic [2:0] sel);
    logic hit;
    logic lvl;
    hit = 1'b0;
    lvl = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (map[i] == sel) begin
        hit = 1'b1;
        lvl = lvl | bits[i];
      end
    end
    return {hit, lvl};
  endfunction : mapHit

  //------------------------------------------------------------------
  // Input synchronisers
  //------------------------------------------------------------------
  localparam int NSYNC = 5 + GP_COUNT;
  logic [NSYNC-1:0] syncA_q;
  logic [NSYNC-1:0] syncB_q;
  logic dsrOk;
  logic ctsOk;
  logic ringIn;
  logic dcdIn;
  logic rxLvl;

  // R20 two-stage sync
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q <= {NSYNC{1'b0}};
      syncB_q <= {NSYNC{1'b0}};
    end else begin
      syncA_q <= {gpIn, ~dsrPin_b, ctsPin, ringPinIn, dcdPinIn, rxPin};
      syncB_q <= syncA_q;
    end
  end
  // Ready pin is low-true at TTL levels
  assign {dsrOk, ctsOk, ringIn, dcdIn, rxLvl} = syncB_q[4:0];

  //------------------------------------------------------------------
  // Millisecond tick and timers
  //------------------------------------------------------------------
  logic [15:0] tickCnt_q, tickCnt_d;
  logic tick;
  logic [15:0] msCnt_q, msCnt_d;
  logic [15:0] stCyc_q, stCyc_d;
  logic stTick;
  logic [7:0] brkCnt_q, brkCnt_d;
  logic brkFire_q, brkFire_d;
  smlc_state_t state_q, state_d;

  assign tick = (tickCnt_q == 16'(MS_CYCLES - 1));
  assign stTick = (stCyc_q == 16'(MS_CYCLES - 1));

  // Tick divider, state timer and break timer
  always_comb begin
    tickCnt_d = tick ? 16'h0000 : tickCnt_q + 16'h0001;
    // State timer restarts on entry so a delay is never cut short
    stCyc_d = stTick ? 16'h0000 : stCyc_q + 16'h0001;
    msCnt_d = msCnt_q;
    if (state_d != state_q) begin
      stCyc_d = 16'h0000;
      msCnt_d = 16'h0000;
    end else if (stTick && msCnt_q != 16'hFFFF) begin
      msCnt_d = msCnt_q + 16'h0001;
    end
    // R11 break length
    brkCnt_d = brkCnt_q;
    brkFire_d = 1'b0;
    if (rxLvl) begin
      brkCnt_d = 8'h00;
    end else if (tick && brkCnt_q != 8'hFF) begin
      brkCnt_d = brkCnt_q + 8'h01;
      // Strictly longer than the limit
      brkFire_d = (brkCnt_q == 8'(BREAK_MS));
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt_q <= 16'h0000;
      stCyc_q <= 16'h0000;
      msCnt_q <= 16'h0000;
      brkCnt_q <= 8'h00;
      brkFire_q <= 1'b0;
    end else begin
      tickCnt_q <= tickCnt_d;
      stCyc_q <= stCyc_d;
      msCnt_q <= msCnt_d;
      brkCnt_q <= brkCnt_d;
      brkFire_q <= brkFire_d;
    end
  end

  //------------------------------------------------------------------
  // Connection state machine
  //------------------------------------------------------------------
  logic dialP, answerP, rejectP, dropP, errP;
  logic peerOk;
  logic autoDial;

  // R17 peer filter
  assign peerOk = !cfg.peerValid || (link.incomingAddr == cfg.peerAddr);
  // R13 auto link-up for the cable master
  assign autoDial = cfg.cableMode && cfg.isMaster && dsrOk;

  always_comb begin
    state_d = state_q;
    dialP = 1'b0;
    answerP = 1'b0;
    rejectP = 1'b0;
    dropP = 1'b0;
    // R4 refuse without ready
    errP = (cmd.dial || cmd.pairable || cmd.bond) && !dsrOk;
    case (state_q)
      ST_IDLE: begin
        if ((cmd.dial && dsrOk) || autoDial) begin
          state_d = ST_DIAL;
          dialP = 1'b1;
        end else if (link.incoming && !cfg.isMaster) begin
          if (peerOk) begin
            state_d = ST_RING;
          end else begin
            rejectP = 1'b1;
          end
        end
      end
      ST_DIAL: begin
        if (link.linkUp) begin
          state_d = ST_LINK;
        end else if (link.linkFail) begin
          // R14 master waits before retrying
          state_d = (cfg.cableMode && cfg.isMaster) ? ST_RETRY : ST_IDLE;
        end
      end
      ST_RETRY: begin
        // R14 programmable delay
        if (stTick && msCnt_q >= clampRetry(cfg.retryMs) - 16'h0001) begin
          state_d = ST_IDLE;
        end
      end
      ST_RING: begin
        // R6 ring held until answered or rejected
        if (link.linkLost) begin
          state_d = ST_IDLE;
        end else if (cmd.hangup) begin
          state_d = ST_IDLE;
          rejectP = 1'b1;
        end else if (cmd.answer || cfg.cableMode) begin
          state_d = ST_LINK;
          answerP = 1'b1;
        end
      end
      ST_LINK, ST_CMD: begin
        if (link.linkLost) begin
          // R13 endless retry after loss
          state_d = (cfg.cableMode && cfg.isMaster) ? ST_RETRY : ST_IDLE;
        end else if (cmd.hangup) begin
          state_d = ST_IDLE;
          dropP = 1'b1;
        end else if (!dsrOk) begin
          // R5 ready drop: command state, then hang up
          state_d = ST_CMD;
          if (state_q == ST_CMD && stTick && msCnt_q >= cfg.disconnectMs) begin
            state_d = ST_IDLE;
            dropP = 1'b1;
          end
        end else begin
          state_d = ST_LINK;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  //------------------------------------------------------------------
  // Line drivers and remote bit mapping
  //------------------------------------------------------------------
  logic linked;
  logic ringOwn, dcdOwn, dtrOwn;
  logic [1:0] dtrMap, ringMap, dcdMap;
  logic ringLine, dcdLine, dtrLine;
  logic [3:0] rmtOut_d;
  logic [GP_COUNT-1:0] gpOut_d, gpOe_d;
  logic [25:0] acc_q, acc_d;
  logic clk8_q, clk8_d;
  logic [25:0] step;

  assign linked = (state_q == ST_LINK) || (state_q == ST_CMD);
  // R6 ring only while an accepted call waits
  assign ringOwn = (state_q == ST_RING);
  // R7 carrier follows the link
  assign dcdOwn = linked;
  // R8 DTR high while a link exists
  assign dtrOwn = linked;
  // R10 remote bits override the local meaning of a mapped line
  assign dtrMap = mapHit(cfg.rmtMap, rmtIn, SEL_DTR);
  assign ringMap = mapHit(cfg.rmtMap, rmtIn, SEL_RI);
  assign dcdMap = mapHit(cfg.rmtMap, rmtIn, SEL_DCD);
  assign dtrLine = dtrMap[1] ? dtrMap[0] : dtrOwn;
  assign ringLine = ringMap[1] ? ringMap[0] : ringOwn;
  assign dcdLine = dcdMap[1] ? dcdMap[0] : dcdOwn;

  // Oscillator output as a phase accumulator at twice the target rate
  assign step = cfg.clkOutHi ? 26'(2 * CLKOUT_HI_HZ) : 26'(2 * CLKOUT_LO_HZ);

  always_comb begin
    // R10 outgoing remote bits sample the mapped local line
    for (int i = 0; i < 4; i++) begin
      case (cfg.rmtMap[i])
        SEL_DTR: rmtOut_d[i] = dtrLine;
        SEL_DSR: rmtOut_d[i] = dsrOk;
        SEL_RI: rmtOut_d[i] = cfg.ringIsOut ? ringLine : ringIn;
        SEL_DCD: rmtOut_d[i] = cfg.dcdIsOut ? dcdLine : dcdIn;
        default: rmtOut_d[i] = 1'b0;
      endcase
    end
    // R18 divided oscillator; limited to mclk/2, so 16 MHz saturates
    acc_d = acc_q;
    clk8_d = clk8_q;
    if (cfg.clkOutEn) begin
      if (acc_q + step >= 26'(CLK_HZ)) begin
        acc_d = acc_q + step - 26'(CLK_HZ);
        clk8_d = ~clk8_q;
        if (acc_d >= 26'(CLK_HZ)) begin
          acc_d = 26'h0000000;
        end
      end else begin
        acc_d = acc_q + step;
      end
    end
    // R9 software owns the general pins by default
    gpOut_d = swGpOut;
    gpOe_d = swGpOe;
    // R8 pin three becomes DTR
    if (cfg.pin3IsDtr || cfg.pureHost) begin
      gpOut_d[0] = dtrLine;
      gpOe_d[0] = 1'b1;
    end
    if (cfg.clkOutEn && cfg.clkOutPin < 3'(GP_COUNT)) begin
      gpOut_d[cfg.clkOutPin] = clk8_q;
      gpOe_d[cfg.clkOutPin] = 1'b1;
    end
  end

  //------------------------------------------------------------------
  // Registered outputs
  //------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      acc_q <= 26'h0000000;
      clk8_q <= 1'b0;
      rtsPin <= 1'b0;
      txEnable <= 1'b0;
      ringPinOut <= 1'b0;
      ringPinOe <= 1'b0;
      dcdPinOut <= 1'b0;
      dcdPinOe <= 1'b0;
      gpOut <= {GP_COUNT{1'b0}};
      gpOe <= {GP_COUNT{1'b0}};
      gpSeen <= {GP_COUNT{1'b0}};
      rmtOut <= 4'h0;
      dialReq <= 1'b0;
      answerReq <= 1'b0;
      rejectReq <= 1'b0;
      dropReq <= 1'b0;
      cmdError <= 1'b0;
      cmdMode <= 1'b1;
      dataPass <= 1'b0;
      breakReset <= 1'b0;
      connState <= 3'h0;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      clk8_q <= clk8_d;
      // R3 fixed UART pair
      // R1 flow control, always active
      rtsPin <= ~rxNearFull;
      txEnable <= ctsOk;
      // R2 ring and carrier direction by setting
      ringPinOut <= ringLine;
      ringPinOe <= cfg.ringIsOut;
      dcdPinOut <= dcdLine;
      dcdPinOe <= cfg.dcdIsOut;
      gpOut <= gpOut_d;
      gpOe <= gpOe_d;
      gpSeen <= syncB_q[NSYNC-1:5];
      rmtOut <= rmtOut_d;
      dialReq <= dialP;
      answerReq <= answerP;
      rejectReq <= rejectP;
      dropReq <= dropP;
      cmdError <= errP;
      // R15 ready drop mode forces command handling
      cmdMode <= (state_d != ST_LINK) || (cfg.readyDrop && !dsrOk);
      dataPass <= (state_d == ST_LINK) && !(cfg.readyDrop && !dsrOk);
      // R12 break stays local; it only resets this device
      breakReset <= brkFire_q;
      connState <= state_d;
    end
  end

endmodule : smlc_line_ctrl
`default_nettype wire

//--- tb/smlc_line_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module smlc_line_ctrl_monitor
  import smlc_pkg::*;
#(
  parameter int MS_CYCLES = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Inputs watched
  input wire smlc_cfg_t cfg,
  input wire smlc_cmd_t cmd,
  input wire smlc_link_t link,
  input wire logic rxPin,
  input wire logic rxNearFull,
  input wire logic ctsPin,
  input wire logic dsrPin_b,
  // Outputs watched
  input wire logic rtsPin,
  input wire logic txEnable,
  input wire logic ringPinOut,
  input wire logic dcdPinOut,
  input wire logic dialReq,
  input wire logic rejectReq,
  input wire logic cmdError,
  input wire logic cmdMode,
  input wire logic breakReset,
  input wire logic [2:0] connState
);
  localparam int BRK_LO = BREAK_MS * MS_CYCLES;
  localparam int BRK_HI = BRK_LO + 2 * MS_CYCLES + 8;
  logic [2:0] upCnt_q, upCnt_d;
  logic [31:0] lowCnt_q, lowCnt_d;
  // -----------------------------------------------
  // Helper counters
  // -----------------------------------------------
  // Edges since reset, so $past never looks into reset
  always_comb begin
    upCnt_d = upCnt_q + {2'h0, upCnt_q != 3'h7};
    lowCnt_d = rxPin ? 32'h0 : lowCnt_q + 32'h1;
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      upCnt_q <= 3'h0;
      lowCnt_q <= 32'h0;
    end else begin
      upCnt_q <= upCnt_d;
      lowCnt_q <= lowCnt_d;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  rts_buffer_a: assert property (
    upCnt_q == 3'h7 |-> rtsPin == !$past(rxNearFull))
    else $error("rts off buffer level");
  cts_sync_a: assert property (
    upCnt_q == 3'h7 |-> txEnable == $past(ctsPin, 3))
    else $error("tx gate off cts");
  dial_refuse_a: assert property (
    dsrPin_b [*4] ##0 (cmd.dial || cmd.pairable || cmd.bond)
    |=> cmdError && !dialReq)
    else $error("request not refused");
  dial_accept_a: assert property (
    (!dsrPin_b) [*4] ##0 (cmd.dial && connState == ST_IDLE)
    |=> dialReq && connState == ST_DIAL)
    else $error("dial not started");
  peer_reject_a: assert property (
    link.incoming && connState == ST_IDLE && !cfg.isMaster &&
    cfg.peerValid && link.incomingAddr != cfg.peerAddr |=> rejectReq)
    else $error("foreign peer kept");
  ring_state_a: assert property (
    $stable(connState) && cfg.ringIsOut && cfg.rmtMap == '0
    |-> ringPinOut == (connState == ST_RING))
    else $error("ring off state");
  carrier_link_a: assert property (
    $stable(connState) && cfg.dcdIsOut && cfg.rmtMap == '0 &&
    (connState == ST_IDLE || connState == ST_LINK)
    |-> dcdPinOut == (connState == ST_LINK))
    else $error("carrier off link");
  drop_command_a: assert property (
    $rose(dsrPin_b) && connState == ST_LINK && cfg.readyDrop
    |-> ##[2:4] (connState == ST_CMD && cmdMode))
    else $error("no command state");
  break_len_a: assert property (
    breakReset |-> lowCnt_q >= BRK_LO && lowCnt_q <= BRK_HI)
    else $error("break reset length");
endmodule : smlc_line_ctrl_monitor
bind smlc_line_ctrl smlc_line_ctrl_monitor #(.MS_CYCLES(MS_CYCLES)) mon (
  .mclk, .rst_b, .cfg, .cmd, .link, .rxPin, .rxNearFull, .ctsPin,
  .dsrPin_b, .rtsPin, .txEnable, .ringPinOut, .dcdPinOut, .dialReq,
  .rejectReq, .cmdError, .cmdMode, .breakReset, .connState
);
`default_nettype wire

//--- tb/smlc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module smlc_host_model (
  // Host intent
  input wire logic wantReady,
  input wire logic wantBreak,
  input wire logic stall,
  // Lines to the device
  input wire logic rtsPin,
  output logic dsrPin_b,
  output logic rxPin,
  output logic ctsPin,
  output logic sendOk
);
  // ready low active
  // Host DTR drives ready; a low level asserts it
  assign dsrPin_b = !wantReady;
  // Break holds receive low, otherwise idle high
  assign rxPin = !wantBreak;
  assign ctsPin = !stall;
  // honour RTS
  // Sending only while granted; a looped cts would overrun
  assign sendOk = rtsPin && !wantBreak;
endmodule : smlc_host_model
`default_nettype wire

//--- tb/smlc_line_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module smlc_line_ctrl_tb;
  import smlc_pkg::*;
  localparam int MS = 20;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  smlc_cfg_t cfg = '0;
  smlc_cmd_t cmd = '0;
  smlc_link_t link = '0;
  logic [3:0] rmtIn = 4'h0;
  logic rxNearFull = 1'b0;
  logic wantReady = 1'b1;
  logic wantBreak = 1'b0;
  logic stall = 1'b0;
  logic [6:0] gpIn = 7'h00, swGpOut = 7'h00, swGpOe = 7'h00;
  logic [47:0] inAddr = 48'h0;
  logic [31:0] seed = 32'h40;
  logic q[$];
  int fail_count = 0;
  int check_count = 0;
  wire logic rxPin, ctsPin, dsrPin_b;
  logic rtsPin, txEnable, ringPinOut, ringPinOe, dcdPinOut, dcdPinOe;
  logic [6:0] gpOut, gpOe, gpSeen;
  logic dialReq, answerReq, rejectReq, dropReq, cmdError, cmdMode, dataPass;
  logic [3:0] rmtOut;
  logic breakReset;
  logic [2:0] connState;
  always #25 mclk = ~mclk;
  smlc_host_model host (.wantReady, .wantBreak, .stall, .rtsPin,
    .dsrPin_b, .rxPin, .ctsPin, .sendOk());
  smlc_line_ctrl #(.MS_CYCLES(MS)) dut (.mclk, .rst_b, .cfg, .cmd,
    .link, .rmtIn, .rxPin, .rxNearFull, .ctsPin, .rtsPin, .txEnable,
    .dsrPin_b, .ringPinIn(1'b0), .ringPinOut, .ringPinOe,
    .dcdPinIn(1'b0), .dcdPinOut, .dcdPinOe, .gpIn, .swGpOut, .swGpOe,
    .gpOut, .gpOe, .gpSeen, .rmtOut, .dialReq, .answerReq,
    .rejectReq, .dropReq, .cmdError, .cmdMode, .dataPass, .breakReset,
    .connState);
  // -----------------------------------------------
  // Helpers
  // -----------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  // Index 0..4 commands, 5..8 radio events; one cycle each
  task automatic pulse(input int k);
    if (k < 5) cmd = smlc_cmd_t'(5'h10 >> k);
    else link = {4'h8 >> (k - 5), inAddr};
    @(negedge mclk);
    cmd = '0;
    link = '0;
  endtask : pulse
  // Bounded wait; n reaches lim when the flag never came
  task automatic waitHi(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
  endtask : waitHi
  // Hang guard sized well past the longest path
  initial begin
    #(50 * 12000);
    fail_count++;
    end_sim();
  end
  initial begin
    int n;
    cfg.ringIsOut = 1'b1;
    cfg.dcdIsOut = 1'b1;
    cfg.pin3IsDtr = 1'b1;
    cfg.pureHost = 1'b1;
    cfg.readyDrop = 1'b1;
    cfg.peerValid = 1'b1;
    cfg.peerAddr = 48'h5A3C_0F12_9E71;
    cfg.disconnectMs = 16'h0005;
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    // Random buffer level and stall; cts seen three cycles late
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      rxNearFull = seed[0];
      stall = seed[1];
      q.push_back(!seed[1]);
      @(negedge mclk);
      chk(rtsPin, !rxNearFull);
      if (q.size() == 3) chk(txEnable, q.pop_front());
    end
    seed = xs(seed);
    {gpIn, swGpOut, swGpOe} = seed[20:0];
    repeat (4) @(negedge mclk);
    chk(gpSeen, gpIn);
    chk(gpOut[6:1], swGpOut[6:1]);
    chk({gpOe, gpOut[0]}, {swGpOe[6:1], 2'b10});
    chk({ringPinOe, dcdPinOe}, 2'b11);
    pulse(0);
    chk({dialReq, connState}, {1'b1, ST_DIAL});
    @(negedge mclk);
    pulse(6);
    wantReady = 1'b0;
    repeat (4) @(negedge mclk);
    for (int k = 0; k < 3; k++) begin
      pulse(k);
      chk({cmdError, dialReq, connState}, 5'h10);
      @(negedge mclk);
    end
    wantReady = 1'b1;
    inAddr = cfg.peerAddr ^ 48'h1;
    repeat (4) @(negedge mclk);
    pulse(8);
    chk(rejectReq, 1'b1);
    @(negedge mclk);
    inAddr = cfg.peerAddr;
    pulse(8);
    @(negedge mclk);
    chk({ringPinOut, connState}, {1'b1, ST_RING});
    pulse(3);
    chk(answerReq, 1'b1);
    @(negedge mclk);
    pulse(5);
    @(negedge mclk);
    chk({connState, ringPinOut, dcdPinOut, gpOut[0], dataPass, cmdMode},
      {ST_LINK, 5'b01110});
    wantReady = 1'b0;
    repeat (4) @(negedge mclk);
    chk({connState, cmdMode, dataPass}, {ST_CMD, 2'b10});
    waitHi(dropReq, 8 * MS, n);
    chk(n >= 4 * MS - 8 && n <= 6 * MS, 1'b1);
    wantReady = 1'b1;
    pulse(7);
    // Retry below the floor must clamp to 100 ms
    cfg.retryMs = 16'h0032;
    cfg.cableMode = 1'b1;
    cfg.isMaster = 1'b1;
    waitHi(dialReq, 40, n);
    chk(dialReq, 1'b1);
    pulse(6);
    chk(connState, ST_RETRY);
    waitHi(dialReq, 150 * MS, n);
    chk(n >= 100 * MS && n <= 100 * MS + 8, 1'b1);
    cfg.cableMode = 1'b0;
    wantBreak = 1'b1;
    waitHi(breakReset, 110 * MS, n);
    chk(n >= 100 * MS && n < 110 * MS, 1'b1);
    repeat (2) @(negedge mclk);
    waitHi(breakReset, 20 * MS, n);
    chk(breakReset, 1'b0);
    wantBreak = 1'b0;
    cfg.rmtMap[RB_IC] = SEL_RI;
    cfg.rmtMap[RB_RTR] = SEL_DSR;
    for (int b = 0; b < 4; b++) begin
      seed = xs(seed);
      rmtIn = seed[3:0];
      repeat (4) @(negedge mclk);
      chk(ringPinOut, rmtIn[RB_IC]);
      chk(rmtOut, {rmtIn[RB_IC], 3'b001});
    end
    end_sim();
  end
endmodule : smlc_line_ctrl_tb
`default_nettype wire
